// file: core/cls_pkg.sv
// Constants, register map and types of the cut-length run sequencer
package cls_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int HALT_TIMEOUT_MS = 3000;
  localparam int HALT_CYCLES = HALT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SPEED_WINDOW_MS = 1000;
  localparam int SPEED_CYCLES = SPEED_WINDOW_MS * (CLK_HZ / 1000);
  localparam int SPEED_SCALE = 60000 / SPEED_WINDOW_MS;
  localparam int TOT_COUNT = 3;
  localparam logic [13:0] QTY_ENDLESS = 14'h270F;
  localparam int PIN_COUNT = 6;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_NEXT_JOB = 8'h08;
  localparam logic [7:0] OFS_NEXT_QTY = 8'h0C;
  localparam logic [7:0] OFS_NEXT_LEN = 8'h10;
  localparam logic [7:0] OFS_PRESS_HOLD = 8'h14;
  localparam logic [7:0] OFS_LOADED = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_CUR_JOB = 8'h20;
  localparam logic [7:0] OFS_CUR_QTY = 8'h24;
  localparam logic [7:0] OFS_CUR_LEN = 8'h28;
  localparam logic [7:0] OFS_REMAIN = 8'h2C;
  localparam logic [7:0] OFS_PAST_SHEAR = 8'h30;
  localparam logic [7:0] OFS_SPEED = 8'h34;
  localparam logic [7:0] OFS_TOT_LEN = 8'h38;
  localparam logic [7:0] OFS_TOT_PCS = 8'h3C;

  localparam int CTRL_REMOTE = 0;
  localparam int CTRL_CONTINUE = 1;
  localparam int CTRL_LINE_RUN = 2;
  localparam int CTRL_METRIC = 3;
  localparam int CTRL_FLYING = 4;
  localparam int CTRL_PUNCH = 5;
  localparam int CTRL_TOT_VIEW = 6;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  localparam int CMD_INC_QTY = 0;
  localparam int CMD_CONFIRM = 1;
  localparam int CMD_CLEAR = 2;
  localparam int CMD_NEXT = 3;
  localparam int CMD_NOW = 4;

  localparam int SB_HALTED = 0;
  localparam int SB_RUN = 1;
  localparam int SB_LINGER = 2;
  localparam int SB_FWD = 3;
  localparam int SB_RUN_OUT = 4;
  localparam int SB_PRESS = 5;
  localparam int SB_PENDING = 6;
  localparam int SB_METRIC = 7;
  localparam int SB_TOT_SEL = 8;

  localparam logic [15:0] PRESS_HOLD_RESET = 16'h0064;

  typedef enum logic [2:0] {
    ST_HALT = 3'b001,
    ST_RUN = 3'b010,
    ST_LINGER = 3'b100
  } cls_state_t;

  typedef struct packed {
    logic [9:0] num;
    logic [13:0] qty;
    logic [31:0] len;
  } cls_job_t;
endpackage

// file: core/cls_sequencer.sv
// Run-control sequencer: run/halt, piece countdown, job change, totalizers
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module cls_sequencer
  import cls_pkg::*;
#(
  parameter int HALT_WAIT = HALT_CYCLES,
  parameter int SPEED_WAIT = SPEED_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RUN_SWITCH,
  input wire logic RUN_CONTACT,
  input wire logic CYCLE_SWITCH,
  input wire logic ENC_STEP,
  input wire logic MOTION,
  input wire logic STROKE_BOTTOM,
  output logic FORWARD_OUT,
  output logic RUN_OUT,
  output logic PRESS_OUT
);

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Pin synchronisers; a level counts once stages two and three agree
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, prev_reg;
  logic [PIN_COUNT-1:0] rise, fall;
  assign pins = {STROKE_BOTTOM, MOTION, ENC_STEP, CYCLE_SWITCH, RUN_CONTACT,
                 RUN_SWITCH};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg) |
                  ((sync2_reg ^ sync3_reg) & filt_reg);
      prev_reg <= filt_reg;
    end
  end

  assign rise = filt_reg & ~prev_reg;
  assign fall = ~filt_reg & prev_reg;

  // Avalon slave: one wait cycle, then the access completes
  logic wait_reg;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic wr_go;
  logic [6:0] ctrl_reg;
  logic [9:0] nx_job_reg;
  logic [13:0] nx_qty_reg;
  logic [31:0] nx_len_reg;
  logic [15:0] press_hold_reg;
  logic [7:0] loaded_reg;
  logic [4:0] cmd;

  assign wr_go = AVS_WRITE && !wait_reg;
  assign cmd = (wr_go && AVS_ADDRESS == OFS_CMD) ?
               (AVS_WRITEDATA[4:0] & {5{AVS_BYTEENABLE[0]}}) : 5'h00;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_reg <= 1'b0;
      rdata_reg <= AVS_READ ? rdata_next : '0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign AVS_WAITREQUEST = wait_reg;
  assign AVS_READDATA = rdata_reg;

  // Settings registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET;
      nx_job_reg <= '0;
      nx_qty_reg <= '0;
      nx_len_reg <= '0;
      press_hold_reg <= PRESS_HOLD_RESET;
    end else if (wr_go) begin
      unique case (AVS_ADDRESS)
        OFS_CTRL: ctrl_reg <= 7'(be_merge({25'h0, ctrl_reg}, AVS_WRITEDATA,
                                        AVS_BYTEENABLE));
        OFS_NEXT_JOB: nx_job_reg <= 10'(be_merge({22'h0, nx_job_reg},
                                        AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_NEXT_QTY: nx_qty_reg <= 14'(be_merge({18'h0, nx_qty_reg},
                                        AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_NEXT_LEN: nx_len_reg <= be_merge(nx_len_reg, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
        OFS_PRESS_HOLD: press_hold_reg <= 16'(be_merge({16'h0,
                          press_hold_reg}, AVS_WRITEDATA, AVS_BYTEENABLE));
        default: ;
      endcase
    end
  end

  // Sequencer state
  cls_state_t state_reg, state_next;
  cls_job_t cur_reg, pend_reg;
  logic pend_valid_reg, now_reg, skip_reg, hold_move_reg, manual_reg;
  logic stroke_wait_reg, keep_move;
  logic [13:0] remain_reg;
  logic [31:0] past_reg, halt_cnt_reg, win_cnt_reg, step_cnt_reg, speed_reg;
  logic [15:0] press_cnt_reg;
  logic press_busy, start_req, halt_req, auto_cut, manual_cut, bottom;
  logic job_done, switch_now, cont_ok, load_pend, halt_evt;
  logic flying, punch, linger_end;
  logic [31:0] len_add;

  assign flying = ctrl_reg[CTRL_FLYING];
  assign punch = ctrl_reg[CTRL_PUNCH];
  assign press_busy = press_cnt_reg != 16'h0000;
  assign start_req = rise[0] || (ctrl_reg[CTRL_REMOTE] && rise[1]);
  assign halt_req = fall[1];
  // Auto cut in run and in linger alike
  // Next stroke waits for the last bottom; a dead bottom input stalls cuts
  assign auto_cut = (state_reg != ST_HALT) && !press_busy &&
                    !stroke_wait_reg && cur_reg.len != 32'h0 &&
                    past_reg >= cur_reg.len;
  assign manual_cut = rise[2] && !press_busy && !stroke_wait_reg &&
                      (state_reg == ST_HALT || flying);
  assign bottom = rise[5];
  assign job_done = auto_cut && !skip_reg && cur_reg.qty != QTY_ENDLESS &&
                    remain_reg == 14'h0001;
  // Loaded parts of the old job go out before the switch
  assign switch_now = auto_cut && pend_valid_reg && now_reg &&
                      loaded_reg <= 8'h01;
  assign cont_ok = ctrl_reg[CTRL_CONTINUE] && pend_valid_reg &&
                   pend_reg.num == cur_reg.num + 10'h001;
  assign load_pend = (state_reg == ST_HALT && start_req && pend_valid_reg) ||
                     switch_now || (job_done && pend_valid_reg);
  assign halt_evt = (switch_now && punch) ||
                    (job_done && !switch_now && !cont_ok);
  assign linger_end = !filt_reg[4] ||
                      halt_cnt_reg >= 32'(HALT_WAIT - 1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HALT: begin
        if (start_req) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (halt_req || halt_evt) begin
          state_next = ST_LINGER;
        end
      end
      ST_LINGER: begin
        if (linger_end) begin
          state_next = ST_HALT;
        end
      end
      default: state_next = ST_HALT;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_HALT;
      halt_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_LINGER) begin
        halt_cnt_reg <= '0;
      end else begin
        halt_cnt_reg <= halt_cnt_reg + 32'h1;
      end
    end
  end

  // Movement outputs; a press under way at the halt from run keeps them up
  // Hold counts in the halt cycle itself, so no one-cycle gap
  assign keep_move = press_busy && (hold_move_reg ||
                     (state_reg == ST_RUN && state_next == ST_LINGER));

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hold_move_reg <= 1'b0;
      FORWARD_OUT <= 1'b0;
      RUN_OUT <= 1'b0;
    end else begin
      if (state_reg == ST_RUN && state_next == ST_LINGER && press_busy) begin
        hold_move_reg <= 1'b1;
      end else if (!press_busy) begin
        hold_move_reg <= 1'b0;
      end
      FORWARD_OUT <= state_next == ST_RUN || keep_move;
      RUN_OUT <= state_next == ST_RUN || keep_move ||
                 (state_next == ST_LINGER &&
                  !ctrl_reg[CTRL_LINE_RUN]);
    end
  end

  // Press timing: output stands for the programmed hold time, one clock when the setting is zero
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      press_cnt_reg <= '0;
      PRESS_OUT <= 1'b0;
      manual_reg <= 1'b0;
      stroke_wait_reg <= 1'b0;
    end else begin
      if (auto_cut || manual_cut) begin
        stroke_wait_reg <= 1'b1;
      end else if (bottom) begin
        stroke_wait_reg <= 1'b0;
      end
      if (auto_cut || manual_cut) begin
        press_cnt_reg <= (press_hold_reg == 16'h0) ? 16'h0001 :
                         press_hold_reg;
        manual_reg <= manual_cut;
        PRESS_OUT <= 1'b1;
      end else if (press_busy) begin
        press_cnt_reg <= press_cnt_reg - 16'h0001;
        PRESS_OUT <= press_cnt_reg != 16'h0001;
      end
    end
  end

  // Flying die keeps the overrun; other strokes reference to zero
  assign len_add = (!manual_reg && flying) ? cur_reg.len : past_reg;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      past_reg <= '0;
    end else if (bottom) begin
      if (!manual_reg && flying) begin
        past_reg <= past_reg - cur_reg.len + {31'h0, rise[3]};
      end else begin
        past_reg <= {31'h0, rise[3]};
      end
    end else if (rise[3]) begin
      past_reg <= past_reg + 32'h1;
    end
  end

  // Job bookkeeping; a new next-job command beats the load
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cur_reg <= '0;
      pend_reg <= '0;
      pend_valid_reg <= 1'b0;
      now_reg <= 1'b0;
      remain_reg <= '0;
      skip_reg <= 1'b0;
      loaded_reg <= '0;
    end else begin
      if (load_pend) begin
        cur_reg <= pend_reg;
        remain_reg <= pend_reg.qty;
        pend_valid_reg <= 1'b0;
      end else if (state_reg == ST_HALT && start_req &&
                   remain_reg == 14'h0) begin
        remain_reg <= cur_reg.qty;
      end else if (auto_cut && !skip_reg && cur_reg.qty != QTY_ENDLESS &&
                   remain_reg != 14'h0) begin
        remain_reg <= remain_reg - 14'h0001;
      end
      if (cmd[CMD_NEXT]) begin
        pend_reg <= '{num: nx_job_reg, qty: nx_qty_reg, len: nx_len_reg};
        pend_valid_reg <= 1'b1;
        now_reg <= cmd[CMD_NOW];
      end
      if (cmd[CMD_INC_QTY]) begin
        skip_reg <= 1'b1;
      end else if (auto_cut) begin
        skip_reg <= 1'b0;
      end
      if (wr_go && AVS_ADDRESS == OFS_LOADED) begin
        loaded_reg <= AVS_WRITEDATA[7:0];
      end else if (auto_cut && loaded_reg != 8'h00) begin
        loaded_reg <= loaded_reg - 8'h01;
      end
    end
  end

  // Totalizers: every stroke books length, auto cuts add a piece
  logic [31:0] tot_len_reg [TOT_COUNT];
  logic [31:0] tot_pcs_reg [TOT_COUNT];
  logic [1:0] tot_sel_reg;
  logic tot_view;
  assign tot_view = ctrl_reg[CTRL_TOT_VIEW];

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tot_sel_reg <= '0;
      for (int i = 0; i < TOT_COUNT; i++) begin
        tot_len_reg[i] <= '0;
        tot_pcs_reg[i] <= '0;
      end
    end else begin
      if (tot_view && cmd[CMD_CONFIRM]) begin
        tot_sel_reg <= (tot_sel_reg == 2'(TOT_COUNT - 1)) ? 2'h0 :
                       tot_sel_reg + 2'h1;
      end
      for (int i = 0; i < TOT_COUNT; i++) begin
        // Clear then add, so no increment is lost in the clear cycle
        tot_len_reg[i] <= ((tot_view && cmd[CMD_CLEAR] &&
                            tot_sel_reg == 2'(i)) ? 32'h0 : tot_len_reg[i])
                          + (bottom ? len_add : 32'h0);
        tot_pcs_reg[i] <= ((tot_view && cmd[CMD_CLEAR] &&
                            tot_sel_reg == 2'(i)) ? 32'h0 : tot_pcs_reg[i])
                          + {31'h0, auto_cut};
      end
    end
  end

  // Line speed per minute from encoder steps in a fixed window
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      win_cnt_reg <= '0;
      step_cnt_reg <= '0;
      speed_reg <= '0;
    end else if (win_cnt_reg >= 32'(SPEED_WAIT - 1)) begin
      win_cnt_reg <= '0;
      step_cnt_reg <= {31'h0, rise[3]};
      speed_reg <= 32'(step_cnt_reg * SPEED_SCALE);
    end else begin
      win_cnt_reg <= win_cnt_reg + 32'h1;
      step_cnt_reg <= step_cnt_reg + {31'h0, rise[3]};
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    unique case (AVS_ADDRESS)
      OFS_CTRL: rdata_next = {25'h0, ctrl_reg};
      OFS_NEXT_JOB: rdata_next = {22'h0, nx_job_reg};
      OFS_NEXT_QTY: rdata_next = {18'h0, nx_qty_reg};
      OFS_NEXT_LEN: rdata_next = nx_len_reg;
      OFS_PRESS_HOLD: rdata_next = {16'h0, press_hold_reg};
      OFS_LOADED: rdata_next = {24'h0, loaded_reg};
      OFS_STATUS: begin
        rdata_next[SB_HALTED] = state_reg == ST_HALT;
        rdata_next[SB_RUN] = state_reg == ST_RUN;
        rdata_next[SB_LINGER] = state_reg == ST_LINGER;
        rdata_next[SB_FWD] = FORWARD_OUT;
        rdata_next[SB_RUN_OUT] = RUN_OUT;
        rdata_next[SB_PRESS] = PRESS_OUT;
        rdata_next[SB_PENDING] = pend_valid_reg;
        rdata_next[SB_METRIC] = ctrl_reg[CTRL_METRIC];
        rdata_next[SB_TOT_SEL +: 2] = tot_sel_reg;
      end
      OFS_CUR_JOB: rdata_next = {22'h0, cur_reg.num};
      OFS_CUR_QTY: rdata_next = {18'h0, cur_reg.qty};
      OFS_CUR_LEN: rdata_next = cur_reg.len;
      OFS_REMAIN: rdata_next = {18'h0, remain_reg};
      OFS_PAST_SHEAR: rdata_next = past_reg;
      OFS_SPEED: rdata_next = speed_reg;
      OFS_TOT_LEN: rdata_next = tot_len_reg[tot_sel_reg];
      OFS_TOT_PCS: rdata_next = tot_pcs_reg[tot_sel_reg];
      default: rdata_next = '0;
    endcase
  end

endmodule

// file: testbench/cls_monitor.sv
// Port-level checks for the run sequencer
`timescale 1ns/1ps
module cls_monitor
  import cls_pkg::*;
#(
  parameter int HALT_WAIT = HALT_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic RUN_SWITCH,
  input wire logic RUN_CONTACT,
  input wire logic FORWARD_OUT,
  input wire logic RUN_OUT,
  input wire logic PRESS_OUT
);
  logic [15:0] hold_reg;
  logic [15:0] pcnt_reg;
  logic [31:0] lcnt_reg;
  // Shadow of the press hold setting, snooped off the bus
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) hold_reg <= PRESS_HOLD_RESET;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_PRESS_HOLD)
      hold_reg <= AVS_WRITEDATA[15:0];
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) pcnt_reg <= 16'h0000;
    else pcnt_reg <= PRESS_OUT ? pcnt_reg + 16'h0001 : 16'h0000;
  end
  // Linger with the line-run bit clear shows as run held with forward dropped
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) lcnt_reg <= 32'h0;
    else lcnt_reg <= (RUN_OUT && !FORWARD_OUT) ? lcnt_reg + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wait_drop_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("request not answered");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("waitrequest low without request");
  start_go_a: assert property ($rose(RUN_SWITCH) && !RUN_OUT && !FORWARD_OUT
    && RUN_CONTACT |-> ##[3:7] FORWARD_OUT) else $error("run not entered");
  fwd_drop_a: assert property ($fell(RUN_CONTACT) && !PRESS_OUT |->
    ##[1:7] (!FORWARD_OUT || PRESS_OUT)) else $error("forward kept on");
  press_keep_a: assert property ($fell(FORWARD_OUT) && !RUN_CONTACT
    |-> !PRESS_OUT) else $error("forward dropped during press");
  linger_cap_a: assert property (lcnt_reg <= HALT_WAIT + 8 + hold_reg)
    else $error("linger too long");
  press_len_a: assert property ($fell(PRESS_OUT) |-> pcnt_reg ==
    (hold_reg == 16'h0000 ? 16'h0001 : hold_reg)) else $error("press width");
  cover property ($rose(PRESS_OUT));
  cover property ($fell(FORWARD_OUT) && RUN_OUT);
  cover property ($fell(RUN_OUT) && !FORWARD_OUT);
endmodule
bind cls_sequencer cls_monitor #(.HALT_WAIT(HALT_WAIT)) mon (
  .CLOCK(CLOCK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RUN_SWITCH(RUN_SWITCH),
  .RUN_CONTACT(RUN_CONTACT), .FORWARD_OUT(FORWARD_OUT), .RUN_OUT(RUN_OUT),
  .PRESS_OUT(PRESS_OUT));

// file: testbench/cls_panel.sv
// Machine model: material feed, encoder and shear stroke
`timescale 1ns/1ps
module cls_panel (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic forward,
  input wire logic press,
  input wire logic slide,
  output logic enc_step,
  output logic motion,
  output logic stroke_bottom
);
  logic [3:0] coast_reg;
  logic [2:0] ph_reg;
  logic [2:0] sdel_reg;
  logic press_reg;
  // Material coasts a little after forward drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) coast_reg <= 4'h0;
    else if (forward) coast_reg <= 4'hC;
    else if (coast_reg != 4'h0) coast_reg <= coast_reg - 4'h1;
  end
  assign motion = forward || slide || (coast_reg != 4'h0);
  // A started encoder pulse always completes, so highs stay 3 clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ph_reg <= 3'h0;
    else if (motion || ph_reg >= 3'h3)
      ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
  end
  assign enc_step = ph_reg >= 3'h3;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) press_reg <= 1'b0;
    else press_reg <= press;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sdel_reg <= 3'h0;
    else if (press && !press_reg) sdel_reg <= 3'h1;
    else if (sdel_reg != 3'h0) sdel_reg <= sdel_reg + 3'h1;
  end
  assign stroke_bottom = sdel_reg[2];
endmodule

// file: testbench/cls_sequencer_tb.sv
// Self-checking bench for the run sequencer
`timescale 1ns/1ps
module cls_sequencer_tb
  import cls_pkg::*;
;
  localparam int HW = 400;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic run_sw = 1'b0;
  logic run_ct = 1'b1;
  logic cyc_sw = 1'b0;
  logic slide = 1'b0;
  logic [31:0] rdata, q, s;
  logic waitreq, enc, motion, stroke, fwd, run_o, press;
  int errors = 0;
  int tests_run = 0;
  int steps = 0;
  int cuts = 0;
  int cyc = 0;
  int n;
  always #5 clock = ~clock;
  always @(posedge enc) steps++;
  always @(posedge press) cuts++;
  cls_sequencer #(.HALT_WAIT(HW), .SPEED_WAIT(100)) dut (
    .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .RUN_SWITCH(run_sw),
    .RUN_CONTACT(run_ct), .CYCLE_SWITCH(cyc_sw), .ENC_STEP(enc),
    .MOTION(motion), .STROKE_BOTTOM(stroke), .FORWARD_OUT(fwd),
    .RUN_OUT(run_o), .PRESS_OUT(press));
  cls_panel model (.clock(clock), .rst_n(rst_n), .forward(fwd),
    .press(press), .slide(slide), .enc_step(enc), .motion(motion),
    .stroke_bottom(stroke));
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clock); while (waitreq !== 1'b0);
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(q, e);
  endtask
  task automatic job(input logic [31:0] j, input logic [31:0] c);
    wr(OFS_NEXT_JOB, j);
    wr(OFS_NEXT_QTY, c);
    wr(OFS_NEXT_LEN, 32'h14);
    wr(OFS_CMD, 32'h8);
  endtask
  task automatic go;
    run_sw <= 1'b1;
    repeat (8) @(posedge clock);
    run_sw <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic whalt;
    do rd(OFS_STATUS); while (q[SB_HALTED] !== 1'b1);
    repeat (10) @(posedge clock);
  endtask
  // Every booked or pending length unit came from one encoder step
  task automatic inv;
    rd(OFS_TOT_LEN);
    s = q;
    rd(OFS_PAST_SHEAR);
    chk(s + q, 32'(steps));
  endtask
  task automatic cut;
    @(negedge press);
    repeat (8) @(posedge clock);
  endtask
  task automatic t_reset;
    rc(OFS_CTRL, {25'h0, CTRL_RESET});
    rc(OFS_PRESS_HOLD, {16'h0, PRESS_HOLD_RESET});
    rc(8'hFC, 32'h0);
    wr(OFS_REMAIN, 32'h5);
    rc(OFS_REMAIN, 32'h0);
    rc(OFS_STATUS, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_count;
    wr(OFS_PRESS_HOLD, 32'h4);
    job(32'h5, 32'h2);
    go();
    rc(OFS_CUR_JOB, 32'h5);
    rc(OFS_CUR_QTY, 32'h2);
    rc(OFS_CUR_LEN, 32'h14);
    wr(OFS_CMD, 32'h1);
    cut();
    rc(OFS_REMAIN, 32'h2);
    cut();
    rc(OFS_REMAIN, 32'h1);
    // Steady feed: one step per 6 clocks, 16 or 17 per window
    rd(OFS_SPEED);
    chk({31'h0, q == 32'h10 * SPEED_SCALE || q == 32'h11 * SPEED_SCALE},
        32'h1);
    whalt();
    rc(OFS_REMAIN, 32'h0);
    rc(OFS_TOT_PCS, 32'h3);
    inv();
    $display("count test done");
  endtask
  task automatic t_halt;
    job(32'h9, {18'h0, QTY_ENDLESS});
    go();
    cut();
    repeat (12) @(posedge clock);
    slide <= 1'b1;
    run_ct <= 1'b0;
    n = cuts;
    repeat (8) @(posedge clock);
    chk({31'h0, fwd}, 32'h0);
    chk({31'h0, run_o}, 32'h1);
    s = 0;
    while (run_o === 1'b1 && s < 600) begin
      @(posedge clock);
      s++;
    end
    chk({31'h0, s > HW - 30 && s < HW + 20}, 32'h1);
    chk({31'h0, cuts > n}, 32'h1);
    rc(OFS_REMAIN, {18'h0, QTY_ENDLESS});
    slide <= 1'b0;
    run_ct <= 1'b1;
    whalt();
    wr(OFS_CTRL, 32'h4);
    wr(OFS_PRESS_HOLD, 32'h20);
    go();
    // Open the contact while a long press is under way
    @(posedge press);
    @(posedge clock);
    run_ct <= 1'b0;
    repeat (8) @(posedge clock);
    chk({31'h0, fwd}, 32'h1);
    chk({31'h0, run_o}, 32'h1);
    @(negedge press);
    repeat (3) @(posedge clock);
    chk({31'h0, fwd}, 32'h0);
    chk({31'h0, run_o}, 32'h0);
    whalt();
    run_ct <= 1'b1;
    $display("halt test done");
  endtask
  task automatic t_next;
    wr(OFS_CTRL, 32'h2);
    job(32'h7, 32'h2);
    go();
    job(32'h8, 32'h1);
    cut();
    rc(OFS_CUR_JOB, 32'h7);
    cut();
    rc(OFS_CUR_JOB, 32'h8);
    rd(OFS_STATUS);
    chk({31'h0, q[SB_RUN]}, 32'h1);
    whalt();
    $display("next job test done");
  endtask
  task automatic t_now;
    wr(OFS_CTRL, 32'h20);
    job(32'h3, 32'h5);
    go();
    wr(OFS_LOADED, 32'h2);
    job(32'h4, 32'h1);
    wr(OFS_CMD, 32'h18);
    cut();
    rc(OFS_CUR_JOB, 32'h3);
    rc(OFS_LOADED, 32'h1);
    rc(OFS_REMAIN, 32'h4);
    whalt();
    rc(OFS_CUR_JOB, 32'h4);
    rc(OFS_REMAIN, 32'h1);
    $display("change now test done");
  endtask
  task automatic t_tot;
    wr(OFS_CTRL, 32'h48);
    rd(OFS_STATUS);
    chk({31'h0, q[SB_METRIC]}, 32'h1);
    chk({30'h0, q[9:8]}, 32'h0);
    rd(OFS_TOT_PCS);
    s = q;
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS);
    chk({30'h0, q[9:8]}, 32'h1);
    rc(OFS_TOT_PCS, s);
    wr(OFS_CMD, 32'h4);
    rc(OFS_TOT_PCS, 32'h0);
    rc(OFS_TOT_LEN, 32'h0);
    wr(OFS_CMD, 32'h2);
    wr(OFS_CMD, 32'h2);
    rc(OFS_TOT_PCS, s);
    slide <= 1'b1;
    repeat (60) @(posedge clock);
    slide <= 1'b0;
    repeat (30) @(posedge clock);
    cyc_sw <= 1'b1;
    repeat (8) @(posedge clock);
    cyc_sw <= 1'b0;
    repeat (40) @(posedge clock);
    rc(OFS_PAST_SHEAR, 32'h0);
    inv();
    $display("totalizer test done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard sized well above the longest expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_halt();
    t_next();
    t_now();
    t_tot();
    results();
  end
endmodule
